// ==== tisl_params.svh ====
// constants for the tag host-port serial slave
`ifndef TISL_PARAMS_SVH
`define TISL_PARAMS_SVH
`define TISL_RES_NONE 4'h0
`define TISL_RES_TUN_RD 4'h1
`define TISL_RES_TUN_WR 4'h3
`define TISL_RES_NORMAL 4'h5
`define TISL_RES_BUSY 4'h7
`define TISL_RES_UNIMPL 4'h8
`define TISL_RES_PARAM 4'hA
`define TISL_RES_SELFDIAG 4'hB
`define TISL_ST_RADIO_BIT 5
`define TISL_ST_FIELD_BIT 4
`define TISL_CMD_READ 8'h08
`define TISL_CMD_WRITE 8'h18
`define TISL_CMD_RREG 8'h68
`define TISL_CMD_WREG 8'h78
`define TISL_CMD_TUNNEL_COMMAND_A 8'hA0
`define TISL_CMD_ANSWER 8'hA8
`define TISL_MEM_SIZE 16'h0200
`define TISL_RD_LEN_MAX 8'hFE
`define TISL_WR_LEN_MAX 8'hFB
`define TISL_FIFO_DEPTH 4
`define TISL_MAX_BYTES 8'hFF
`endif

// ==== tisl_pkg.sv ====
// types for the tag host-port serial slave
package tisl_pkg;
   typedef enum {
      TISL_IDLE, TISL_ADDR, TISL_ADDR_ACK, TISL_RX, TISL_RX_ACK,
      TISL_TX, TISL_TX_ACK, TISL_IGNORE
   } tisl_state_type;
   typedef struct packed {
      logic scl;
      logic sda;
   } tisl_bus_in_type;
   typedef struct packed {
      logic radio_command_event_flag;
      logic field_detect_event_flag;
      logic [3:0] command_result_code;
   } tisl_status_type;
endpackage

// ==== tisl_fifo.sv ====
// small valid/ready fifo for received write data bytes
`timescale 1ns/10ps
module tisl_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // write side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // read side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } tisl_fifo_state_type;
   tisl_fifo_state_type st_ff, nxt_st;
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic push, pop;
   assign in_ready_out = (st_ff.cnt != (AW+1)'(DEPTH));
   assign out_valid_out = (st_ff.cnt != '0);
   assign out_data_out = mem_ff[st_ff.rp];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         nxt_st.wp = (st_ff.wp == AW'(DEPTH-1)) ? '0 : st_ff.wp + 1'b1;
      end
      if (pop) begin
         nxt_st.rp = (st_ff.rp == AW'(DEPTH-1)) ? '0 : st_ff.rp + 1'b1;
      end
      nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
      if (push) begin
         mem_ff[st_ff.wp] <= in_data_in;
      end
   end
   a_fifo_no_overflow: assert property (@(posedge clk_in)
      disable iff (!rst_b_in) st_ff.cnt <= (AW+1)'(DEPTH))
      else $error("fifo count above depth");
endmodule

// ==== tisl_slave.sv ====
// serial slave host port of the tag: framing, command decode, status reply
// Notes on behaviour
// - host is master, this port only slave
// - command write, then result on next read
// - read without command returns current status
// - address byte then zero to 255 bytes
// - matched address, write bit: receive command
// - matched address, read bit: send response
// - own address comes from memory setting
// - status bits seven and six read zero
// - status bit five shows radio command event
// - status bit four shows field detect event
// - low four status bits carry result
// - result 0x0 means no information
// - tunnel read 0x1, tunnel write 0x3
// - busy 0x7, normal completion 0x5
// - 0x8 unimplemented or idle tunnel command
// - 0xA address or length out of range
// - 0xB write to read-only area
// - error or busy: status byte only
`timescale 1ns/10ps
`include "tisl_params.svh"
module tisl_slave (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   // serial bus, open drain data
   input wire tisl_pkg::tisl_bus_in_type BUS_IN,
   output logic SDA_OUT,
   output logic SDA_OE_OUT,
   // configuration and tag-side status
   input wire logic [6:0] OWN_BUS_ADDRESS_SETTING_IN,
   input wire logic RADIO_COMMAND_EVENT_FLAG_IN,
   input wire logic FIELD_DETECT_EVENT_FLAG_IN,
   input wire logic TUNNEL_READ_REQ_IN,
   input wire logic TUNNEL_WRITE_REQ_IN,
   input wire logic TUNNEL_ACTIVE_IN,
   input wire logic [15:0] READ_ONLY_LIMIT_IN,
   input wire logic CORE_BUSY_IN,
   input wire logic [7:0] REPLY_DATA_IN,
   // decoded command towards the tag core
   output logic CMD_START_OUT,
   output logic [7:0] CMD_CODE_OUT,
   output logic [15:0] CMD_ADDR_OUT,
   output logic [7:0] CMD_LEN_OUT,
   output logic WR_DATA_VALID_OUT,
   output logic [7:0] WR_DATA_OUT,
   output logic REPLY_ADVANCE_OUT
);
   import tisl_pkg::*;
   typedef struct packed {
      tisl_state_type fsm;
      logic scl_d;
      logic sda_d;
      logic [7:0] shift;
      logic [3:0] bit_cnt;
      logic [7:0] byte_cnt;
      logic [7:0] code;
      logic [15:0] addr;
      logic [7:0] len;
      logic [3:0] result;
      logic pending;
      logic data_ok;
      logic last_nack;
      logic sda_oe;
      logic cmd_start;
      logic wr_valid;
      logic [7:0] wr_data;
      logic advance;
   } tisl_reg_type;
   tisl_reg_type r_ff, nxt_r;
   tisl_status_type status;
   logic [7:0] status_byte;
   logic scl_rise, scl_fall, start_cond, stop_cond;
   logic fifo_in_ready, fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic push_byte;
   assign scl_rise = BUS_IN.scl && !r_ff.scl_d;
   assign scl_fall = !BUS_IN.scl && r_ff.scl_d;
   assign start_cond = BUS_IN.scl && r_ff.scl_d && r_ff.sda_d && !BUS_IN.sda;
   assign stop_cond = BUS_IN.scl && r_ff.scl_d && !r_ff.sda_d && BUS_IN.sda;
   always_comb begin
      status.radio_command_event_flag = RADIO_COMMAND_EVENT_FLAG_IN;
      status.field_detect_event_flag = FIELD_DETECT_EVENT_FLAG_IN;
      status.command_result_code = r_ff.result;
      if (CORE_BUSY_IN) begin
         status.command_result_code = `TISL_RES_BUSY;
      end
      status_byte = {2'b00, status};
   end
   // data bytes received with a write command travel through the fifo to the tag core
   assign push_byte = (r_ff.fsm == TISL_RX_ACK) && scl_fall
      && r_ff.byte_cnt >= 8'd4 && r_ff.code == `TISL_CMD_WRITE;
   tisl_fifo #(.WIDTH(8), .DEPTH(`TISL_FIFO_DEPTH)) u_fifo (
      .clk_in(CLK_IN),
      .rst_b_in(RST_B_IN),
      .in_valid_in(push_byte),
      .in_ready_out(fifo_in_ready),
      .in_data_in(r_ff.shift),
      .out_valid_out(fifo_out_valid),
      .out_ready_in(!CORE_BUSY_IN),
      .out_data_out(fifo_out_data)
   );
   function automatic logic [3:0] check_cmd(input logic [7:0] c,
      input logic [15:0] a, input logic [7:0] n, input logic tun,
      input logic [15:0] ro);
      logic [3:0] res;
      logic [16:0] last;
      res = `TISL_RES_NORMAL;
      last = {1'b0, a} + {9'd0, n};
      case (c)
         `TISL_CMD_READ, `TISL_CMD_WRITE: begin
            if (n == 8'h00 || last > {1'b0, `TISL_MEM_SIZE}
               || (c == `TISL_CMD_READ && n > `TISL_RD_LEN_MAX)
               || (c == `TISL_CMD_WRITE && n > `TISL_WR_LEN_MAX)) begin
               res = `TISL_RES_PARAM;
            end else if (c == `TISL_CMD_WRITE && a < ro) begin
               res = `TISL_RES_SELFDIAG;
            end
         end
         `TISL_CMD_RREG, `TISL_CMD_WREG: res = `TISL_RES_NORMAL;
         `TISL_CMD_TUNNEL_COMMAND_A, `TISL_CMD_ANSWER: begin
            if (!tun) begin
               res = `TISL_RES_UNIMPL;
            end
         end
         default: res = `TISL_RES_UNIMPL;
      endcase
      return res;
   endfunction
   always_comb begin
      nxt_r = r_ff;
      nxt_r.scl_d = BUS_IN.scl;
      nxt_r.sda_d = BUS_IN.sda;
      nxt_r.cmd_start = 1'b0;
      nxt_r.wr_valid = fifo_out_valid && !CORE_BUSY_IN;
      nxt_r.wr_data = fifo_out_data;
      nxt_r.advance = 1'b0;
      if (!r_ff.pending && !CORE_BUSY_IN) begin
         if (TUNNEL_READ_REQ_IN) begin
            nxt_r.result = `TISL_RES_TUN_RD;
         end else if (TUNNEL_WRITE_REQ_IN) begin
            nxt_r.result = `TISL_RES_TUN_WR;
         end
      end
      if (start_cond) begin
         nxt_r.fsm = TISL_ADDR;
         nxt_r.bit_cnt = '0;
         nxt_r.sda_oe = 1'b0;
      end else if (stop_cond) begin
         if (r_ff.fsm == TISL_RX || r_ff.fsm == TISL_RX_ACK) begin
            if (r_ff.byte_cnt != 8'd0) begin
               nxt_r.result = check_cmd(r_ff.code, r_ff.addr, r_ff.len,
                  TUNNEL_ACTIVE_IN, READ_ONLY_LIMIT_IN);
               nxt_r.pending = 1'b1;
               nxt_r.cmd_start = 1'b1;
            end
         end
         nxt_r.fsm = TISL_IDLE;
         nxt_r.sda_oe = 1'b0;
      end else begin
         case (r_ff.fsm)
            TISL_IDLE: nxt_r.fsm = TISL_IDLE;
            TISL_ADDR, TISL_RX: begin
               if (scl_rise) begin
                  nxt_r.shift = {r_ff.shift[6:0], BUS_IN.sda};
                  nxt_r.bit_cnt = r_ff.bit_cnt + 4'd1;
               end else if (scl_fall && r_ff.bit_cnt == 4'd8) begin
                  nxt_r.bit_cnt = '0;
                  if (r_ff.fsm == TISL_RX) begin
                     nxt_r.fsm = TISL_RX_ACK;
                     nxt_r.sda_oe = fifo_in_ready
                        || r_ff.byte_cnt < 8'd4; // ack
                  end else if (r_ff.shift[7:1]
                     == OWN_BUS_ADDRESS_SETTING_IN) begin
                     nxt_r.fsm = TISL_ADDR_ACK;
                     nxt_r.sda_oe = 1'b1;
                  end else begin
                     nxt_r.fsm = TISL_IGNORE;
                  end
               end
            end
            TISL_ADDR_ACK: begin
               if (scl_fall) begin
                  nxt_r.byte_cnt = '0;
                  nxt_r.sda_oe = 1'b0;
                  if (r_ff.shift[0]) begin
                     nxt_r.fsm = TISL_TX;
                     nxt_r.shift = status_byte;
                     nxt_r.sda_oe = !status_byte[7];
                     nxt_r.data_ok = r_ff.pending && !CORE_BUSY_IN
                        && r_ff.result == `TISL_RES_NORMAL
                        && (r_ff.code == `TISL_CMD_READ
                        || r_ff.code == `TISL_CMD_RREG);
                     nxt_r.pending = CORE_BUSY_IN && r_ff.pending;
                     if (!CORE_BUSY_IN) begin
                        nxt_r.result = `TISL_RES_NONE;
                     end
                  end else begin
                     nxt_r.fsm = TISL_RX;
                  end
               end
            end
            TISL_RX_ACK: begin
               if (scl_fall) begin
                  nxt_r.sda_oe = 1'b0;
                  nxt_r.fsm = TISL_RX;
                  if (r_ff.byte_cnt != `TISL_MAX_BYTES) begin
                     nxt_r.byte_cnt = r_ff.byte_cnt + 8'd1;
                  end
                  case (r_ff.byte_cnt)
                     8'd0: nxt_r.code = r_ff.shift;
                     8'd1: nxt_r.addr[15:8] = r_ff.shift;
                     8'd2: nxt_r.addr[7:0] = r_ff.shift;
                     8'd3: nxt_r.len = r_ff.shift;
                     default: nxt_r.len = r_ff.len;
                  endcase
                  if (r_ff.byte_cnt == 8'd0) begin
                     nxt_r.addr = '0;
                     nxt_r.len = '0;
                  end
               end
            end
            TISL_TX: begin
               if (scl_fall) begin
                  nxt_r.bit_cnt = r_ff.bit_cnt + 4'd1;
                  nxt_r.shift = {r_ff.shift[6:0], 1'b0};
                  nxt_r.sda_oe = !r_ff.shift[6];
                  if (r_ff.bit_cnt == 4'd7) begin
                     nxt_r.fsm = TISL_TX_ACK;
                     nxt_r.sda_oe = 1'b0;
                     nxt_r.bit_cnt = '0;
                  end
               end
            end
            TISL_TX_ACK: begin
               if (scl_rise) begin
                  nxt_r.last_nack = BUS_IN.sda;
               end else if (scl_fall) begin
                  if (r_ff.last_nack || !r_ff.data_ok
                     || r_ff.byte_cnt >= r_ff.len) begin
                     nxt_r.fsm = TISL_IGNORE;
                     nxt_r.sda_oe = 1'b0;
                  end else begin
                     nxt_r.fsm = TISL_TX;
                     nxt_r.byte_cnt = r_ff.byte_cnt + 8'd1;
                     nxt_r.shift = REPLY_DATA_IN;
                     nxt_r.sda_oe = !REPLY_DATA_IN[7];
                     nxt_r.advance = 1'b1;
                  end
               end
            end
            TISL_IGNORE: nxt_r.fsm = TISL_IGNORE;
            default: nxt_r.fsm = TISL_IDLE;
         endcase
      end
   end
   always_ff @(posedge CLK_IN) begin
      if (!RST_B_IN) begin
         r_ff <= '0;
         r_ff.fsm <= TISL_IDLE;
         r_ff.scl_d <= 1'b1;
         r_ff.sda_d <= 1'b1;
      end else begin
         r_ff <= nxt_r;
      end
   end
   assign SDA_OUT = 1'b0;
   assign SDA_OE_OUT = r_ff.sda_oe;
   assign CMD_START_OUT = r_ff.cmd_start;
   assign CMD_CODE_OUT = r_ff.code;
   assign CMD_ADDR_OUT = r_ff.addr;
   assign CMD_LEN_OUT = r_ff.len;
   assign WR_DATA_VALID_OUT = r_ff.wr_valid;
   assign WR_DATA_OUT = r_ff.wr_data;
   assign REPLY_ADVANCE_OUT = r_ff.advance;
   a_status_top_zero: assert property (@(posedge CLK_IN)
      disable iff (!RST_B_IN) status_byte[7:6] == 2'b00)
      else $error("status top bits not zero");
   a_status_radio_bit: assert property (@(posedge CLK_IN)
      disable iff (!RST_B_IN)
      status_byte[5] == RADIO_COMMAND_EVENT_FLAG_IN)
      else $error("radio event bit wrong");
   a_status_field_bit: assert property (@(posedge CLK_IN)
      disable iff (!RST_B_IN)
      status_byte[4] == FIELD_DETECT_EVENT_FLAG_IN)
      else $error("field event bit wrong");
   a_busy_code_shown: assert property (@(posedge CLK_IN)
      disable iff (!RST_B_IN) CORE_BUSY_IN |-> status_byte[3:0] == 4'h7)
      else $error("busy code not shown");
   a_addr_match_ack: assert property (@(posedge CLK_IN)
      disable iff (!RST_B_IN) (r_ff.fsm == TISL_ADDR_ACK)
      |-> r_ff.sda_oe && r_ff.shift[7:1] == OWN_BUS_ADDRESS_SETTING_IN)
      else $error("matched address not acked");
   a_stop_starts_cmd: assert property (@(posedge CLK_IN)
      disable iff (!RST_B_IN) r_ff.cmd_start |-> r_ff.pending
      && r_ff.fsm == TISL_IDLE)
      else $error("command start without pending");
   a_error_no_data: assert property (@(posedge CLK_IN)
      disable iff (!RST_B_IN) (r_ff.fsm == TISL_TX && r_ff.byte_cnt != 8'd0)
      |-> r_ff.data_ok)
      else $error("data sent after non normal status");
   a_unimpl_code: assert property (@(posedge CLK_IN)
      disable iff (!RST_B_IN) $rose(r_ff.cmd_start) && !$past(CORE_BUSY_IN)
      && r_ff.code == 8'h55 |-> r_ff.result == 4'h8)
      else $error("unimplemented code not flagged");
   c_cmd_write: cover property (@(posedge CLK_IN) r_ff.cmd_start);
   c_read_tx: cover property (@(posedge CLK_IN) r_ff.fsm == TISL_TX);
   c_data_byte: cover property (@(posedge CLK_IN) r_ff.advance);
endmodule

// ==== tisl_host.sv ====
// bus master model standing in for the host on the tag serial port
`timescale 1ns/10ps
module tisl_host #(
   parameter int HALF = 12
) (
   // clock
   input wire logic clk_in,
   // wires of the serial bus
   input wire logic sda_oe_in,
   output tisl_pkg::tisl_bus_in_type bus_out
);
   import tisl_pkg::*;
   // ****************
   // wire levels
   // ****************
   logic scl = 1'b1;
   logic drv_low = 1'b0;
   // open drain with pull-up: a released wire reads high
   assign bus_out.scl = scl;
   assign bus_out.sda = ~(drv_low | sda_oe_in);
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic put_bit(input logic b);
      drv_low = ~b;
      tick(HALF);
      scl = 1'b1;
      tick(HALF);
      scl = 1'b0;
      tick(2);
   endtask
   task automatic get_bit(output logic b);
      drv_low = 1'b0;
      tick(HALF);
      scl = 1'b1;
      tick(HALF / 2);
      b = bus_out.sda;
      tick(HALF - HALF / 2);
      scl = 1'b0;
      tick(2);
   endtask
   task automatic start();
      drv_low = 1'b0;
      tick(HALF);
      scl = 1'b1;
      tick(HALF);
      drv_low = 1'b1;
      tick(HALF);
      scl = 1'b0;
      tick(2);
   endtask
   task automatic stop();
      drv_low = 1'b1;
      tick(HALF);
      scl = 1'b1;
      tick(HALF);
      drv_low = 1'b0;
      tick(HALF);
   endtask
   // msb first, returns the slave's acknowledge
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      get_bit(a);
      ack = ~a;
   endtask
   task automatic rd_byte(output logic [7:0] d, input logic ack);
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
      put_bit(~ack);
   endtask
endmodule

// ==== tb.sv ====
// self-checking bench for the tag serial slave
`timescale 1ns/10ps
module tb;
   import tisl_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   tisl_bus_in_type bus;
   logic sda_o, oe, cstart, wv, adv, acked;
   logic [6:0] own = 7'h52;
   logic radio = 1'b0, field = 1'b0, trd = 1'b0, twr = 1'b0;
   logic tact = 1'b0, busy = 1'b0;
   logic [15:0] rol = 16'h0000;
   logic [7:0] reply = 8'hC3;
   logic [7:0] code, clen, wd, r0;
   logic [15:0] caddr;
   logic [7:0] tx[12];
   logic [7:0] rx[4];
   logic [7:0] wq[$];
   int nstart = 0, mismatches = 0, compares = 0;
   logic [31:0] ecmd[9] = '{32'h5500_0001, 32'hA000_0001, 32'hA800_0001,
      32'h0802_0001, 32'h0800_1000, 32'h0800_10FF, 32'h1800_0401,
      32'h6800_0000, 32'h7800_0000};
   logic [3:0] eres[9] = '{4'h8, 4'h8, 4'h8, 4'hA, 4'hA, 4'hA, 4'hB,
      4'h5, 4'h5};
   initial begin
      forever #20 clk = ~clk;
   end
   tisl_host #(.HALF(12)) u_host (.clk_in(clk), .sda_oe_in(oe), .bus_out(bus));
   tisl_slave u_dut (.CLK_IN(clk), .RST_B_IN(rst_b), .BUS_IN(bus),
      .SDA_OUT(sda_o), .SDA_OE_OUT(oe), .OWN_BUS_ADDRESS_SETTING_IN(own),
      .RADIO_COMMAND_EVENT_FLAG_IN(radio), .FIELD_DETECT_EVENT_FLAG_IN(field),
      .TUNNEL_READ_REQ_IN(trd), .TUNNEL_WRITE_REQ_IN(twr),
      .TUNNEL_ACTIVE_IN(tact), .READ_ONLY_LIMIT_IN(rol), .CORE_BUSY_IN(busy),
      .REPLY_DATA_IN(reply), .CMD_START_OUT(cstart), .CMD_CODE_OUT(code),
      .CMD_ADDR_OUT(caddr), .CMD_LEN_OUT(clen), .WR_DATA_VALID_OUT(wv),
      .WR_DATA_OUT(wd), .REPLY_ADVANCE_OUT(adv));
   // core side: collect write bytes, count starts, step reply data
   always @(posedge clk) begin
      if (wv === 1'b1) wq.push_back(wd);
      if (cstart === 1'b1) nstart++;
      if (adv === 1'b1) reply <= reply + 8'h01;
   end
   // ****************
   // access tasks
   // ****************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // stops at the first refused byte, returns bytes acked with address
   task automatic wr_frame(input logic [6:0] a, input int n, output int k);
      logic ok;
      k = 0;
      ok = 1'b1;
      u_host.start();
      for (int i = 0; i <= n && ok === 1'b1; i++) begin
         u_host.wr_byte(i == 0 ? {a, 1'b0} : tx[i-1], ok);
         if (ok === 1'b1) k++;
      end
      u_host.stop();
   endtask
   task automatic rd_frame(input logic [6:0] a, input int n);
      u_host.start();
      u_host.wr_byte({a, 1'b1}, acked);
      for (int i = 0; i < n && acked === 1'b1; i++) begin
         u_host.rd_byte(rx[i], i < n - 1);
      end
      u_host.stop();
   endtask
   task automatic cmd(input logic [31:0] h, input int nd, output int k);
      {tx[0], tx[1], tx[2], tx[3]} = h;
      for (int i = 0; i < nd; i++) tx[4+i] = 8'h10 + 8'(i);
      wr_frame(own, 4 + nd, k);
   endtask
   task automatic st(input logic [7:0] exp, input logic only);
      rd_frame(own, 2);
      chk(rx[0], exp);
      if (only) chk(rx[1], 8'hFF);
   endtask
   // ****************
   // sequence
   // ****************
   initial begin
      int n;
      repeat (4) @(posedge clk);
      #1 rst_b = 1'b1;
      chk({oe, cstart, wv, adv, sda_o}, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         {radio, field} = 2'(i);
         u_host.tick(2);
         st({2'b00, 2'(i), 4'h0}, 1'b0);
      end
      {radio, field} = 2'b00;
      rd_frame(7'h2D, 1);
      chk(acked, 1'b0);
      own = 7'h2D;
      rd_frame(7'h2D, 1);
      chk(acked, 1'b1);
      cmd(32'h1801_2002, 2, n);
      chk(16'(n), 16'h0007);
      chk(16'(nstart), 16'h0001);
      chk(code, 8'h18);
      chk(caddr, 16'h0120);
      chk(clen, 8'h02);
      chk({wq[0], wq[1]}, 16'h1011);
      st(8'h05, 1'b0);
      st(8'h00, 1'b0);
      cmd(32'h0800_1003, 0, n);
      r0 = reply;
      rd_frame(own, 4);
      chk(rx[0], 8'h05);
      for (int i = 1; i < 4; i++) chk(rx[i], r0 + 8'(i - 1));
      rol = 16'h0010;
      for (int i = 0; i < 9; i++) begin
         cmd(ecmd[i], int'(ecmd[i][31:24] == 8'h18), n);
         st({4'h0, eres[i]}, 1'b1);
      end
      tact = 1'b1;
      cmd(32'hA000_0001, 0, n);
      st(8'h05, 1'b1);
      tact = 1'b0;
      trd = 1'b1;
      u_host.tick(4);
      trd = 1'b0;
      st(8'h01, 1'b0);
      twr = 1'b1;
      u_host.tick(4);
      twr = 1'b0;
      st(8'h03, 1'b0);
      wq.delete();
      busy = 1'b1;
      st(8'h07, 1'b1);
      cmd(32'h1801_0006, 6, n);
      chk(16'(n), 16'h0009);
      chk(16'(wq.size()), 16'h0000);
      busy = 1'b0;
      for (n = 0; n < 300 && wq.size() < 4; n++) u_host.tick(1);
      chk(16'(wq.size()), 16'h0004);
      if (wq.size() >= 4) begin
         for (int i = 0; i < 4; i++) chk(wq[i], 8'h10 + 8'(i));
      end
      stop_test();
   end
endmodule
